// file: logic/edw_window.sv
/*
  Extended data page window: page registers, address extension, read
  overhead timing, double-word splitting, page-zero trap and interrupt.
  Assumes the core waits for done before its next request and that the
  memory side answers a read strobe within its own cycle and holds the
  data until the next strobe.
*/
`timescale 1ns/1ps
// How it works
// [R1] Extended space split into 32 Kbyte pages; read or write page chosen.
// [R2] Program visibility reads use only the read page register.
// [R3] Page value joined to the core address gives a 24-bit address.
// [R4] Window access with page zero selected raises an address error trap.
// [R5] Window read: read page low 9 bits above address low 15 bits.
// [R6] Address bit 15 set means an access through the window.
// [R7] Every window read costs one extra cycle; here primed repeat reads and the second word of a double word skip it.
// [R8] In a repeat run the first two reads share one extra cycle.
// [R9] Reach of internal and external memory depends on the device variant.
// [R10] Window reaches internal memory above 32 Kbytes and external memory.
// [R11] Window also gives read-only access into program memory.
// [R12] Window write: write page low 9 bits above address low 15 bits.
// [R13] Page registers never step when a pointer wraps within the page.
// [R14] Window writes complete in a single cycle; here a double-word write takes two cycles.
// [R15] Addresses below 8000h ignore both page registers.
// [R16] All sizes use the same address; double word is two word transfers.
module edw_window (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // Core request
  input  wire logic                core_rd,
  input  wire logic                core_wr,
  input  wire logic [15:0]         core_ea,
  input  wire edw_pkg::edw_size_e  core_size,
  input  wire logic                core_repeat,
  input  wire logic [31:0]         core_wdata,
  // Core answer
  output logic                     core_busy_ff,
  output logic                     core_done_ff,
  output logic                     core_trap_ff,
  output logic [31:0]              core_rdata_ff,
  // Memory side
  output edw_pkg::edw_mem_s        mem_req_ff,
  output logic [15:0]              mem_wdata_ff,
  input  wire logic [15:0]         mem_rdata,
  // Register port
  input  wire logic [3:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [15:0]              reg_rdata_ff,
  // Interrupt
  output logic                     irq_ff
);

  logic [9:0]           read_page_select_ff;
  logic [8:0]           write_page_select_ff;
  logic [1:0]           status_ff;
  logic [1:0]           mask_ff;
  logic [1:0]           nxt_status;
  edw_pkg::edw_state_e  state_ff;
  edw_pkg::edw_map_s    map;
  logic                 take;
  logic                 primed_ff;
  logic                 second_ff;
  logic                 is_rd_ff;
  logic                 dword_ff;
  logic [15:0]          high_word_ff;
  logic [1:0]           event_set;

  assign take = (state_ff == edw_pkg::ST_IDLE) & (core_rd | core_wr);

  edw_addr_map u_map (
    .effective_address (core_ea),
    .is_read           (core_rd),
    .read_page_select  (read_page_select_ff),
    .write_page_select (write_page_select_ff),
    .map               (map)
  );

  // Page registers change only on a software write
  always_ff @(posedge clock) begin
    if (rst) begin
      read_page_select_ff  <= edw_pkg::RPAGE_RST;
      write_page_select_ff <= edw_pkg::WPAGE_RST;
    end else if (reg_wr && reg_addr == edw_pkg::RPAGE_OFS) begin
      read_page_select_ff  <= reg_wdata[9:0]; // [R13]
    end else if (reg_wr && reg_addr == edw_pkg::WPAGE_OFS) begin
      write_page_select_ff <= reg_wdata[8:0]; // [R13]
    end
  end

  // Events: page-zero trap and a double word running off the page end
  always_comb begin
    event_set = 2'h0;
    event_set[edw_pkg::EV_PAGE_ZERO] = take & map.page_zero;
    event_set[edw_pkg::EV_WRAP] = take & ~map.page_zero & map.window
      & (core_size == edw_pkg::SZ_DWORD)
      & (core_ea[14:0] == edw_pkg::LAST_WORD);
  end

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    nxt_status = status_ff;
    if (reg_wr && reg_addr == edw_pkg::STATUS_OFS) begin
      nxt_status = status_ff & ~reg_wdata[1:0];
    end
    nxt_status = nxt_status | event_set;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      status_ff <= edw_pkg::STATUS_RST;
      mask_ff   <= edw_pkg::MASK_RST;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      if (reg_wr && reg_addr == edw_pkg::MASK_OFS) begin
        mask_ff <= reg_wdata[1:0];
      end
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == edw_pkg::RPAGE_OFS) begin
        reg_rdata_ff <= {6'h00, read_page_select_ff};
      end else if (reg_addr == edw_pkg::WPAGE_OFS) begin
        reg_rdata_ff <= {7'h00, write_page_select_ff};
      end else if (reg_addr == edw_pkg::STATUS_OFS) begin
        reg_rdata_ff <= {14'h0000, status_ff};
      end else if (reg_addr == edw_pkg::MASK_OFS) begin
        reg_rdata_ff <= {14'h0000, mask_ff};
      end else begin
        reg_rdata_ff <= 16'h0000;
      end
    end else begin
      reg_rdata_ff <= 16'h0000;
    end
  end

  // Repeat runs: after the first window read the next ones skip overhead
  always_ff @(posedge clock) begin
    if (rst) begin
      primed_ff <= 1'b0;
    end else if (take && !core_repeat) begin
      primed_ff <= 1'b0;
    end else if (take && core_rd && map.window && !map.page_zero) begin
      primed_ff <= 1'b1; // [R8]
    end
  end

  // Access sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff       <= edw_pkg::ST_IDLE;
      mem_req_ff     <= '0;
      mem_wdata_ff   <= 16'h0000;
      core_busy_ff   <= 1'b0;
      core_done_ff   <= 1'b0;
      core_trap_ff   <= 1'b0;
      core_rdata_ff  <= 32'h0000_0000;
      second_ff      <= 1'b0;
      is_rd_ff       <= 1'b0;
      dword_ff       <= 1'b0;
      high_word_ff   <= 16'h0000;
    end else begin
      mem_req_ff.rd <= 1'b0;
      mem_req_ff.wr <= 1'b0;
      core_done_ff  <= 1'b0;
      core_trap_ff  <= 1'b0;
      case (state_ff)
        edw_pkg::ST_IDLE: begin
          if (take && map.page_zero) begin
            core_trap_ff <= 1'b1; // [R4]
            core_done_ff <= 1'b1;
          end else if (take) begin
            mem_req_ff.addr     <= map.addr; // [R16]
            mem_req_ff.window   <= map.window; // [R10]
            mem_req_ff.prog_vis <= map.prog_vis; // [R11]
            mem_req_ff.size     <= (core_size == edw_pkg::SZ_BYTE) ?
                                   edw_pkg::SZ_BYTE : edw_pkg::SZ_WORD;
            mem_req_ff.rd       <= core_rd;
            // Program memory is never written through the window
            mem_req_ff.wr       <= core_wr; // [R11]
            mem_wdata_ff        <= core_wdata[15:0];
            high_word_ff        <= core_wdata[31:16];
            is_rd_ff            <= core_rd;
            dword_ff            <= (core_size == edw_pkg::SZ_DWORD);
            second_ff           <= 1'b0;
            core_busy_ff        <= 1'b1;
            if (core_wr && core_size == edw_pkg::SZ_DWORD) begin
              state_ff <= edw_pkg::ST_SECOND; // [R16]
            end else if (core_wr) begin
              core_busy_ff <= 1'b0;
              core_done_ff <= 1'b1; // [R14]
            end else if (map.window && !(core_repeat && primed_ff)) begin
              state_ff <= edw_pkg::ST_EXTRA; // [R7]
            end else begin
              state_ff <= edw_pkg::ST_DATA; // [R8]
            end
          end
        end
        edw_pkg::ST_EXTRA: begin
          state_ff <= edw_pkg::ST_DATA; // [R7]
        end
        edw_pkg::ST_DATA: begin
          if (second_ff) begin
            core_rdata_ff[31:16] <= mem_rdata;
          end else begin
            core_rdata_ff <= {16'h0000, mem_rdata};
          end
          if (dword_ff && !second_ff) begin
            // Offset wraps inside the page, page stays put
            mem_req_ff.addr[14:0] <= mem_req_ff.addr[14:0]
                                     + edw_pkg::WORD_STEP; // [R13] [R16]
            mem_req_ff.rd <= 1'b1;
            second_ff     <= 1'b1;
          end else begin
            core_busy_ff <= 1'b0;
            core_done_ff <= 1'b1;
            state_ff     <= edw_pkg::ST_IDLE;
          end
        end
        edw_pkg::ST_SECOND: begin
          mem_req_ff.addr[14:0] <= mem_req_ff.addr[14:0]
                                   + edw_pkg::WORD_STEP; // [R16]
          mem_req_ff.wr <= 1'b1;
          mem_wdata_ff  <= high_word_ff;
          core_busy_ff  <= 1'b0;
          core_done_ff  <= 1'b1; // [R14]
          state_ff      <= edw_pkg::ST_IDLE;
        end
        default: begin
          state_ff     <= edw_pkg::ST_IDLE;
          core_busy_ff <= 1'b0;
        end
      endcase
    end
  end

  chk_trap_on_zero: assert property ( // [R4]
    @(posedge clock) disable iff (rst)
    take && map.page_zero |=> core_trap_ff && core_done_ff && !mem_req_ff.rd
      && !mem_req_ff.wr)
    else $error("page zero window access did not trap");

  chk_read_addr: assert property ( // [R5]
    @(posedge clock) disable iff (rst)
    take && core_rd && core_ea[15] && !map.page_zero |=>
      mem_req_ff.rd && mem_req_ff.addr
        == {$past(read_page_select_ff[8:0]), $past(core_ea[14:0])})
    else $error("window read address not formed from read page");

  chk_write_addr: assert property ( // [R12]
    @(posedge clock) disable iff (rst)
    take && core_wr && core_ea[15] && !map.page_zero |=>
      mem_req_ff.wr && mem_req_ff.addr
        == {$past(write_page_select_ff), $past(core_ea[14:0])})
    else $error("window write address not formed from write page");

  chk_base_direct: assert property ( // [R15]
    @(posedge clock) disable iff (rst)
    take && !core_ea[15] |=>
      mem_req_ff.addr == {8'h00, $past(core_ea)} && !mem_req_ff.window)
    else $error("base access used a page register");

  chk_read_extra: assert property ( // [R7]
    @(posedge clock) disable iff (rst)
    take && core_rd && core_ea[15] && !map.page_zero && !primed_ff
      && core_size != edw_pkg::SZ_DWORD |=> !core_done_ff ##1 !core_done_ff
      ##1 core_done_ff)
    else $error("window read did not take one extra cycle");

  chk_repeat_fast: assert property ( // [R8]
    @(posedge clock) disable iff (rst)
    take && core_rd && core_ea[15] && core_repeat && primed_ff
      && !map.page_zero && core_size != edw_pkg::SZ_DWORD
      |=> !core_done_ff ##1 core_done_ff)
    else $error("primed repeat read took overhead");

  chk_write_single: assert property ( // [R14]
    @(posedge clock) disable iff (rst)
    take && core_wr && core_size != edw_pkg::SZ_DWORD && !map.page_zero |=>
      core_done_ff && mem_req_ff.wr && !core_busy_ff)
    else $error("write did not complete in one cycle");

  chk_page_stable: assert property ( // [R13]
    @(posedge clock) disable iff (rst)
    !(reg_wr && (reg_addr == edw_pkg::RPAGE_OFS
      || reg_addr == edw_pkg::WPAGE_OFS)) |=>
      $stable(read_page_select_ff) && $stable(write_page_select_ff))
    else $error("page register changed without a software write");

  chk_prog_read_only: assert property ( // [R11]
    @(posedge clock) disable iff (rst)
    mem_req_ff.prog_vis && state_ff != edw_pkg::ST_SECOND |-> !mem_req_ff.wr)
    else $error("program visibility access wrote memory");

  chk_dword_second: assert property ( // [R16]
    @(posedge clock) disable iff (rst)
    take && core_wr && core_size == edw_pkg::SZ_DWORD && !map.page_zero
      |=> mem_req_ff.wr ##1 mem_req_ff.wr && core_done_ff
      && mem_req_ff.addr[23:15] == $past(mem_req_ff.addr[23:15]))
    else $error("double word write not two word transfers in one page");

endmodule // edw_window

// file: logic/edw_pkg.sv
/*
  Shared constants and types of the extended data page window.
  Assumes one 50 MHz core clock and a synchronous active-high reset.
*/
package edw_pkg;

  // Address widths
  localparam int EA_W      = 16;
  localparam int OFS_W     = 15;
  localparam int PAGE_W    = 9;
  localparam int RPAGE_W   = 10;
  localparam int XA_W      = 24;
  localparam int WORD_W    = 16;

  // Window geometry: one page is the 32 Kbyte window
  localparam int          WINDOW_BIT   = 15;
  localparam int          PROG_VIS_BIT = 9;
  localparam int          PAGE_BYTES   = 32768;
  localparam logic [14:0] LAST_WORD    = 15'h7ffe;
  localparam logic [14:0] WORD_STEP    = 15'h0002;

  // Register port
  localparam int          REG_AW        = 4;
  localparam logic [3:0]  RPAGE_OFS     = 4'h0;
  localparam logic [3:0]  WPAGE_OFS     = 4'h1;
  localparam logic [3:0]  STATUS_OFS    = 4'h2;
  localparam logic [3:0]  MASK_OFS      = 4'h3;
  localparam logic [9:0]  RPAGE_RST     = 10'h001;
  localparam logic [8:0]  WPAGE_RST     = 9'h001;
  localparam logic [1:0]  STATUS_RST    = 2'h0;
  localparam logic [1:0]  MASK_RST      = 2'h0;
  localparam int          EV_PAGE_ZERO  = 0;
  localparam int          EV_WRAP       = 1;
  localparam int          EV_N          = 2;

  // Cycles a window read spends beyond a base read
  localparam int          READ_EXTRA    = 1;

  typedef enum logic [2:0] {
    SZ_BYTE  = 3'b001,
    SZ_WORD  = 3'b010,
    SZ_DWORD = 3'b100
  } edw_size_e;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_EXTRA  = 4'b0010,
    ST_DATA   = 4'b0100,
    ST_SECOND = 4'b1000
  } edw_state_e;

  // Result of mapping one core address
  typedef struct packed {
    logic [23:0] addr;
    logic        window;
    logic        prog_vis;
    logic        page_zero;
  } edw_map_s;

  // Request presented to the memory side
  typedef struct packed {
    logic [23:0] addr;
    logic        rd;
    logic        wr;
    logic        window;
    logic        prog_vis;
    edw_size_e   size;
  } edw_mem_s;

endpackage

// file: logic/edw_addr_map.sv
/*
  Combinational mapping of a 16-bit effective address onto the 24-bit
  extended space. Assumes the caller registers the result.
*/
`timescale 1ns/1ps
module edw_addr_map (
  // Core address and direction
  input  wire logic [15:0]       effective_address,
  input  wire logic              is_read,
  // Page selects
  input  wire logic [9:0]        read_page_select,
  input  wire logic [8:0]        write_page_select,
  // Mapped result
  output edw_pkg::edw_map_s      map
);

  logic [8:0] page;

  always_comb begin
    page = is_read ? read_page_select[8:0] : write_page_select; // [R1] [R2]
    map.window    = effective_address[edw_pkg::WINDOW_BIT]; // [R6]
    // Program visibility only ever comes from the read page
    map.prog_vis  = is_read & map.window
                    & read_page_select[edw_pkg::PROG_VIS_BIT]; // [R2] [R11]
    map.page_zero = map.window & (page == 9'h000)
                    & ~map.prog_vis; // [R4]
    if (map.window) begin
      map.addr = {page, effective_address[14:0]}; // [R3] [R5] [R9] [R12]
    end else begin
      map.addr = {8'h00, effective_address}; // [R15]
    end
  end

endmodule // edw_addr_map

// file: verif/edw_mem_model.sv
/*
  Memory behind the extended data page window: answers read strobes.
  Assumes the window samples read data in the strobe cycle or later,
  held until the next strobe of either kind.
*/
`timescale 1ns/1ps
module edw_mem_model (
  // Clock and memory request
  input  wire logic               clock,
  input  wire edw_pkg::edw_mem_s  mem_req,
  // Read data back to the window
  output logic [15:0]             mem_rdata
);
  logic [15:0]                    held_ff;
  logic [15:0]                    pattern;
  initial held_ff = 16'h0000;
  // Data follow the address so a wrong page or offset shows
  assign pattern = mem_req.addr[15:0] ^ {mem_req.addr[23:16], 8'h3c};
  // Answer inside the strobe cycle, then hold until the next strobe
  assign mem_rdata = (mem_req.rd === 1'b1) ? pattern : held_ff;
  always @(posedge clock) begin
    if (mem_req.rd === 1'b1) begin
      held_ff <= pattern;
    end else if (mem_req.wr === 1'b1) begin
      // Stale data are not kept past a new strobe
      held_ff <= ~held_ff;
    end
  end
endmodule // edw_mem_model

// file: verif/edw_window_bench.sv
/*
  Self-checking bench of the extended data page window.
  Assumes the memory model above stands on the memory side.
*/
`timescale 1ns/1ps
module edw_window_bench;
  logic               clock, rst, core_rd, core_wr, core_repeat;
  logic [15:0]        core_ea, mem_wdata_ff, mem_rdata, reg_wdata;
  logic [15:0]        reg_rdata_ff, reg_q[$];
  logic [31:0]        core_wdata, core_rdata_ff, m, wd;
  edw_pkg::edw_size_e core_size;
  logic               core_busy_ff, core_done_ff, core_trap_ff, irq_ff;
  edw_pkg::edw_mem_s  mem_req_ff;
  logic [3:0]         reg_addr;
  logic               reg_wr, reg_rd, rd_pend;
  int                 miscompares, comparisons, cyc;
  logic [42:0]        mem_q[$];
  logic [66:0]        done_q[$], e;
  logic [8:0]         rp, wp;
  logic [14:0]        ofs;
  logic [23:0]        a0, a1;

  edw_window i_dut (
    .clock(clock), .rst(rst), .core_rd(core_rd), .core_wr(core_wr),
    .core_ea(core_ea), .core_size(core_size),
    .core_repeat(core_repeat), .core_wdata(core_wdata),
    .core_busy_ff(core_busy_ff), .core_done_ff(core_done_ff),
    .core_trap_ff(core_trap_ff), .core_rdata_ff(core_rdata_ff),
    .mem_req_ff(mem_req_ff), .mem_wdata_ff(mem_wdata_ff),
    .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .irq_ff(irq_ff)
  );
  edw_mem_model i_mem (
    .clock(clock), .mem_req(mem_req_ff), .mem_rdata(mem_rdata)
  );

  function automatic logic [15:0] pat(input logic [23:0] a);
    return a[15:0] ^ {a[23:16], 8'h3c};
  endfunction

  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [66:0] got, input logic [66:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_op(input logic wr, input logic [3:0] a,
                        input logic [15:0] d);
    @(posedge clock);
    if (!wr) reg_q.push_back(d);
    reg_wr    <= wr;
    reg_rd    <= !wr;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  task automatic exp_mem(input logic [23:0] a, input logic rd,
                         input logic pv, input logic [15:0] d);
    mem_q.push_back({a, rd, !rd, pv, rd ? 16'h0000 : d});
  endtask

  task automatic core_op(input logic wr, input logic [15:0] ea,
    input edw_pkg::edw_size_e sz, input logic rep, input logic [31:0] w,
    input int lat, input logic [1:0] ms, input logic tr,
    input logic [31:0] d);
    int n;
    @(posedge clock);
    done_q.push_back({ms, tr, d, 32'(cyc + 1 + lat)});
    core_rd     <= !wr;
    core_wr     <= wr;
    core_ea     <= ea;
    core_size   <= sz;
    core_repeat <= rep;
    core_wdata  <= w;
    @(posedge clock);
    core_rd <= 1'b0;
    core_wr <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n == 1) cmp(67'(core_busy_ff), 67'(lat > 1));
    end while (core_done_ff !== 1'b1 && n < 20);
    if (n >= 20) cmp(67'(0), 67'(1));
  endtask

  // Scoreboard: oldest note per kind against each result
  always @(negedge clock) begin
    if (core_done_ff === 1'b1) begin
      e = done_q.size() ? done_q.pop_front() : '1;
      m = e[66] ? 32'hffff_ffff : {16'h0000, {16{e[65]}}};
      cmp({e[66:65], core_trap_ff, core_rdata_ff & m, 32'(cyc)}, e);
    end
    if ((mem_req_ff.rd | mem_req_ff.wr) === 1'b1) begin
      cmp(67'({mem_req_ff.addr, mem_req_ff.rd, mem_req_ff.wr,
        mem_req_ff.prog_vis, mem_req_ff.wr ? mem_wdata_ff : 16'h0000}),
        67'(mem_q.size() ? mem_q.pop_front() : '1));
    end
    if (rd_pend === 1'b1) cmp(67'(reg_rdata_ff), 67'(reg_q.pop_front()));
    rd_pend = reg_rd;
  end

  always @(posedge clock) cyc <= cyc + 1;

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Whole run is well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    summarize();
  end

  initial begin
    {rst, core_rd, core_wr, core_repeat, reg_wr, reg_rd} = 6'h20;
    {core_ea, core_wdata, reg_wdata, reg_addr} = '0;
    {miscompares, comparisons, cyc, rd_pend} = '0;
    core_size = edw_pkg::SZ_WORD;
    void'($urandom(32'h0ade));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    reg_op(0, edw_pkg::RPAGE_OFS, {6'h00, edw_pkg::RPAGE_RST});
    reg_op(0, edw_pkg::WPAGE_OFS, {7'h00, edw_pkg::WPAGE_RST});
    reg_op(0, edw_pkg::STATUS_OFS, 16'h0000);
    reg_op(0, edw_pkg::MASK_OFS, 16'h0000);
    reg_op(0, 4'h9, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rp = 9'($urandom_range(511, 1));
      wp = 9'($urandom_range(511, 1));
      ofs = 15'($urandom) & 15'h7ffc;
      wd = $urandom;
      reg_op(1, edw_pkg::RPAGE_OFS, {7'h00, rp});
      reg_op(1, edw_pkg::WPAGE_OFS, {7'h00, wp});
      exp_mem({rp, ofs}, 1, 0, 0);
      core_op(0, {1'b1, ofs}, edw_pkg::SZ_WORD, 0, 0,
        2 + edw_pkg::READ_EXTRA, 2'b01, 0, {16'h0, pat({rp, ofs})});
      exp_mem({wp, ofs}, 0, 0, wd[15:0]);
      core_op(1, {1'b1, ofs}, i[0] ? edw_pkg::SZ_BYTE : edw_pkg::SZ_WORD,
        0, wd, 1, 2'b00, 0, 0);
      exp_mem({9'h000, ofs}, 1, 0, 0);
      core_op(0, {1'b0, ofs}, edw_pkg::SZ_WORD, 0, 0, 2, 2'b01, 0,
        {16'h0, pat({9'h000, ofs})});
    end
    // Only the first read of a repeat run pays the extra cycle
    for (int j = 0; j < 3; j++) begin
      a0 = {rp, ofs + 15'(2 * j)};
      exp_mem(a0, 1, 0, 0);
      core_op(0, {1'b1, a0[14:0]}, edw_pkg::SZ_WORD, 1, 0,
        j ? 2 : 3, 2'b01, 0, {16'h0, pat(a0)});
    end
    // Write page zero must not matter for program visibility
    reg_op(1, edw_pkg::RPAGE_OFS, {6'h00, 1'b1, rp});
    reg_op(1, edw_pkg::WPAGE_OFS, 16'h0000);
    exp_mem({rp, ofs}, 1, 1, 0);
    core_op(0, {1'b1, ofs}, edw_pkg::SZ_WORD, 0, 0, 3, 2'b01, 0,
      {16'h0, pat({rp, ofs})});
    reg_op(1, edw_pkg::MASK_OFS, 16'h0001);
    reg_op(1, edw_pkg::RPAGE_OFS, 16'h0000);
    core_op(0, 16'h8000, edw_pkg::SZ_WORD, 0, 0, 1, 2'b00, 1, 0);
    core_op(1, 16'hc000, edw_pkg::SZ_WORD, 0, wd, 1, 2'b00, 1, 0);
    reg_op(0, edw_pkg::STATUS_OFS, 16'h0001);
    @(negedge clock);
    cmp(67'(irq_ff), 67'(1));
    reg_op(1, edw_pkg::STATUS_OFS, 16'h0001);
    reg_op(0, edw_pkg::STATUS_OFS, 16'h0000);
    @(negedge clock);
    cmp(67'(irq_ff), 67'(0));
    // Double word across the page end: offset wraps, page stays
    reg_op(1, edw_pkg::RPAGE_OFS, {7'h00, rp});
    reg_op(1, edw_pkg::WPAGE_OFS, {7'h00, wp});
    a0 = {rp, 15'h7ffe};
    a1 = {rp, 15'h0000};
    exp_mem(a0, 1, 0, 0);
    exp_mem(a1, 1, 0, 0);
    core_op(0, 16'hfffe, edw_pkg::SZ_DWORD, 0, 0, 4, 2'b10, 0,
      {pat(a1), pat(a0)});
    exp_mem({wp, 15'h7ffe}, 0, 0, wd[15:0]);
    exp_mem({wp, 15'h0000}, 0, 0, wd[31:16]);
    core_op(1, 16'hfffe, edw_pkg::SZ_DWORD, 0, wd, 2, 2'b00, 0, 0);
    reg_op(0, edw_pkg::RPAGE_OFS, {7'h00, rp});
    reg_op(0, edw_pkg::WPAGE_OFS, {7'h00, wp});
    reg_op(0, edw_pkg::STATUS_OFS, 16'h0002);
    @(negedge clock);
    cmp(67'(irq_ff), 67'(0));
    reg_op(1, edw_pkg::MASK_OFS, 16'h0003);
    @(negedge clock);
    @(negedge clock);
    cmp(67'(irq_ff), 67'(1));
    reg_op(1, edw_pkg::STATUS_OFS, 16'h0002);
    @(negedge clock);
    @(negedge clock);
    cmp(67'(irq_ff), 67'(0));
    repeat (3) @(posedge clock);
    summarize();
  end
endmodule // edw_window_bench
